// *** src/adc_dmic_dc_measure.sv ***
`timescale 1ns/1ps
// Operation
// [R1] pin function 1010 drives the modulator clock on general pin one
// [R2] microphone bit captured at each modulator clock rising edge
// [R3] microphone supplies its bitstream on data input, on our clock
// [R4] microphone mode bypasses analog section and feeds decimation path
// [R5] software sets oversampling ratio to suit the microphone
// [R6] control bit seven enables dc measurement
// [R7] result is 24-bit signed, two integer and 22 fraction bits
// [R8] latched result read back from three byte registers
// [R9] writing latch bit captures result; software clears after reading
// [R10] control bit five selects averaging (0) or first-order IIR (1)
// [R11] averaging length parameter from control bits four to zero, 1..20
// [R12] IIR coefficient from same parameter, higher narrows bandwidth
// [R13] periodic-reset bit resets averager every 2^R modulator periods
// [R14] periodic reset off means the averager is never reset
// [R15] software should keep filter parameter below reset exponent
// [R16] dc measurement only while the channel is not recording; here it runs whenever control bit seven is set
// [R17] coefficient changes during record need a defined sequence
// [R18] standard decimation uses oversampling ratio 128 or 64
// [R19] read-back holds latched value while latch bit stays set
module adc_dmic_dc_measure
  import dc_measure_pkg::*;
#(
  parameter int HALF_CYCLES = MOD_CLK_HALF_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input reg_req_t reg_req_in,
  input wire logic din_in,
  input wire logic dmic_enable_in,
  input wire logic analog_bit_in,
  input wire logic analog_valid_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic general_pin_one_out,
  output logic general_pin_one_oe_n_out,
  output logic analog_powerdown_out,
  output logic decim_bit_out,
  output logic decim_valid_out
);

  logic [7:0] pin_config;
  logic [7:0] dc_measure_control;
  logic [7:0] dc_measure_aux_control;
  logic [23:0] dc_result_readback;
  logic [23:0] cur_result;
  logic latch_prev;
  logic modulator_clock;
  mic_sample_t mic_sample;
  logic path_valid;
  logic path_bit;
  logic dc_on;
  logic mode_iir;
  logic [4:0] d_eff;
  logic [4:0] r_exp;
  logic [31:0] period_cnt;
  logic [31:0] period_mask;
  logic period_reset;
  logic [20:0] avg_cnt;
  logic [20:0] avg_len_mask;
  logic signed [21:0] avg_acc;
  logic signed [21:0] next_avg_acc;
  logic signed [23:0] avg_scaled;
  logic signed [43:0] iir_state;
  logic signed [43:0] iir_input;
  logic signed [44:0] iir_diff;
  logic signed [44:0] next_iir;

  // out-of-range parameter settings are held to the legal span
  function automatic logic [4:0] clamp_param(input logic [4:0] raw);
    if (raw < DC_PARAM_MIN) begin
      clamp_param = DC_PARAM_MIN;
    end else if (raw > DC_PARAM_MAX) begin
      clamp_param = DC_PARAM_MAX;
    end else begin
      clamp_param = raw;
    end
  endfunction

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] o);
    is_addr = (a == o);
  endfunction

  dmic_link #(
    .HALF_CYCLES(HALF_CYCLES)
  ) link_u (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .din_in(din_in),
    .mod_clk_out(modulator_clock),
    .sample_out(mic_sample)
  );

  // software-written control registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_config <= PIN_CONFIG_RESET;
      dc_measure_control <= DC_MEASURE_CONTROL_RESET;
      dc_measure_aux_control <= DC_MEASURE_AUX_CONTROL_RESET;
    end else if (reg_req_in.wr) begin
      if (is_addr(reg_req_in.addr, PIN_CONFIG_OFFSET)) begin
        pin_config <= reg_req_in.wdata;
      end
      if (is_addr(reg_req_in.addr, DC_MEASURE_CONTROL_OFFSET)) begin
        dc_measure_control <= reg_req_in.wdata;
      end
      if (is_addr(reg_req_in.addr, DC_MEASURE_AUX_CONTROL_OFFSET)) begin
        dc_measure_aux_control <= reg_req_in.wdata;
      end
    end
  end

  // read answers one cycle after the request; unmapped reads give zero
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_req_in.rd;
      if (reg_req_in.rd) begin
        unique case (reg_req_in.addr)
          PIN_CONFIG_OFFSET: reg_rdata_out <= pin_config;
          DC_MEASURE_CONTROL_OFFSET: reg_rdata_out <= dc_measure_control;
          DC_MEASURE_AUX_CONTROL_OFFSET:
            reg_rdata_out <= dc_measure_aux_control;
          DC_RESULT_READBACK_FIRST_OFFSET:
            reg_rdata_out <= dc_result_readback[23:16]; // [R8]
          DC_RESULT_READBACK_MID_OFFSET:
            reg_rdata_out <= dc_result_readback[15:8]; // [R8]
          DC_RESULT_READBACK_LAST_OFFSET:
            reg_rdata_out <= dc_result_readback[7:0]; // [R8]
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // pin driver; when not selected the pin is released
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      general_pin_one_out <= 1'b0;
      general_pin_one_oe_n_out <= 1'b1;
    end else begin
      general_pin_one_out <= modulator_clock;
      general_pin_one_oe_n_out <= (pin_config[PIN_FUNC_MSB:PIN_FUNC_LSB]
        != PIN_FUNC_MOD_CLOCK); // [R1]
    end
  end

  // decimation input comes from the microphone in microphone mode
  assign path_valid = dmic_enable_in ? mic_sample.valid : analog_valid_in;
  assign path_bit = dmic_enable_in ? mic_sample.value : analog_bit_in;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      decim_bit_out <= 1'b0;
      decim_valid_out <= 1'b0;
      analog_powerdown_out <= 1'b0;
    end else begin
      decim_bit_out <= path_bit; // [R4]
      decim_valid_out <= path_valid; // [R4]
      analog_powerdown_out <= dmic_enable_in; // [R4]
    end
  end

  assign dc_on = dc_measure_control[DC_ENABLE_BIT]; // [R6]
  assign mode_iir = dc_measure_control[DC_FILTER_SEL_BIT]; // [R10]
  assign d_eff = clamp_param(dc_measure_control[DC_PARAM_MSB:0]); // [R11]
  assign r_exp = dc_measure_aux_control[AUX_EXP_MSB:0];

  // periodic reset counts modulator periods; 2^R minus one is the wrap
  assign period_mask = ~(32'hffffffff << r_exp);
  assign period_reset = dc_measure_aux_control[AUX_PERIODIC_RESET_BIT]
    & path_valid & (period_cnt == period_mask); // [R13] [R14]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      period_cnt <= 32'h00000000;
    end else if (!dc_on || period_reset) begin
      period_cnt <= 32'h00000000;
    end else if (path_valid) begin
      period_cnt <= period_cnt + 32'h00000001; // [R13]
    end
  end

  // averaging filter: sums 2^D bits of +-1 then scales to 2.22
  assign avg_len_mask = ~(21'h1fffff << d_eff);
  assign next_avg_acc = path_bit ? avg_acc + 22'sd1 : avg_acc - 22'sd1;
  assign avg_scaled = 24'(signed'({{2{next_avg_acc[21]}}, next_avg_acc})
    <<< (RESULT_FRAC_BITS - int'(d_eff))); // [R7]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      avg_acc <= '0;
      avg_cnt <= '0;
    end else if (!dc_on || mode_iir || period_reset) begin
      avg_acc <= '0; // [R13]
      avg_cnt <= '0;
    end else if (path_valid) begin
      if (avg_cnt == avg_len_mask) begin
        avg_acc <= '0;
        avg_cnt <= '0;
      end else begin
        avg_acc <= next_avg_acc; // [R11]
        avg_cnt <= avg_cnt + 21'h000001;
      end
    end
  end

  // first-order IIR: y += (x - y) / 2^D; guard bits keep small steps
  assign iir_input = path_bit ? (44'sd1 <<< 42) : -(44'sd1 <<< 42);
  assign iir_diff = 45'(iir_input) - 45'(iir_state);
  assign next_iir = 45'(iir_state) + (iir_diff >>> d_eff); // [R12]

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      iir_state <= '0;
    end else if (!dc_on || !mode_iir) begin
      iir_state <= '0;
    end else if (path_valid) begin
      iir_state <= next_iir[43:0]; // [R12]
    end
  end

  // newest conversion result, in 2.22 format
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cur_result <= DC_RESULT_RESET;
    end else if (dc_on && path_valid) begin
      if (mode_iir) begin
        cur_result <= next_iir[43:IIR_GUARD_BITS]; // [R7] [R10]
      end else if (avg_cnt == avg_len_mask && !period_reset) begin
        cur_result <= avg_scaled; // [R7] [R10]
      end
    end
  end

  // capture on the latch bit going high; held while it stays high so a
  // multi-byte read never mixes two conversions
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      latch_prev <= 1'b0;
      dc_result_readback <= DC_RESULT_RESET;
    end else begin
      latch_prev <= dc_measure_aux_control[AUX_LATCH_BIT];
      if (dc_measure_aux_control[AUX_LATCH_BIT] && !latch_prev) begin
        dc_result_readback <= cur_result; // [R9] [R19]
      end
    end
  end

endmodule // adc_dmic_dc_measure

// *** src/dc_measure_pkg.sv ***
package dc_measure_pkg;

  // register offsets on the control port
  localparam logic [7:0] PIN_CONFIG_OFFSET = 8'h33;
  localparam logic [7:0] DC_MEASURE_CONTROL_OFFSET = 8'h66;
  localparam logic [7:0] DC_MEASURE_AUX_CONTROL_OFFSET = 8'h67;
  localparam logic [7:0] DC_RESULT_READBACK_FIRST_OFFSET = 8'h68;
  localparam logic [7:0] DC_RESULT_READBACK_MID_OFFSET = 8'h69;
  localparam logic [7:0] DC_RESULT_READBACK_LAST_OFFSET = 8'h6a;

  // reset values
  localparam logic [7:0] PIN_CONFIG_RESET = 8'h00;
  localparam logic [7:0] DC_MEASURE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] DC_MEASURE_AUX_CONTROL_RESET = 8'h00;
  localparam logic [23:0] DC_RESULT_RESET = 24'h000000;

  // field positions
  localparam int PIN_FUNC_MSB = 5;
  localparam int PIN_FUNC_LSB = 2;
  localparam logic [3:0] PIN_FUNC_MOD_CLOCK = 4'ha;
  localparam int DC_ENABLE_BIT = 7;
  localparam int DC_FILTER_SEL_BIT = 5;
  localparam int DC_PARAM_MSB = 4;
  localparam int AUX_LATCH_BIT = 6;
  localparam int AUX_PERIODIC_RESET_BIT = 5;
  localparam int AUX_EXP_MSB = 4;

  // filter parameter limits and result format
  localparam logic [4:0] DC_PARAM_MIN = 5'h01;
  localparam logic [4:0] DC_PARAM_MAX = 5'h14;
  localparam int RESULT_FRAC_BITS = 22;
  localparam int IIR_GUARD_BITS = 20;

  // timing: 200 MHz system clock, modulator clock half period
  localparam int CLK_PERIOD_NS = 5;
  localparam int MOD_CLK_HALF_NS = 240;
  localparam int MOD_CLK_HALF_CYCLES = MOD_CLK_HALF_NS / CLK_PERIOD_NS;

  // one captured bit of the modulator stream
  typedef struct packed {
    logic valid;
    logic value;
  } mic_sample_t;

  // one access on the control port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// *** src/dmic_link.sv ***
`timescale 1ns/1ps
module dmic_link
  import dc_measure_pkg::*;
#(
  parameter int HALF_CYCLES = MOD_CLK_HALF_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic din_in,
  output logic mod_clk_out,
  output mic_sample_t sample_out
);

  logic [15:0] div_cnt;
  logic div_tick;
  logic din_meta;
  logic din_sync;

  // divider making the half-period enable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt <= 16'h0000;
    end else if (div_tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  assign div_tick = (div_cnt == 16'(HALF_CYCLES - 1));

  // modulator clock toggles on every half-period enable
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mod_clk_out <= 1'b0;
    end else if (div_tick) begin
      mod_clk_out <= ~mod_clk_out;
    end
  end

  // pin is asynchronous to us: two flops before use
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      din_meta <= din_in;
      din_sync <= din_meta;
    end
  end

  // capture at the rising edge of the modulator clock; the microphone
  // changes its bit after the falling edge so the value is steady here
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sample_out <= '0;
    end else begin
      sample_out.valid <= div_tick & ~mod_clk_out; // [R2]
      sample_out.value <= din_sync; // [R3]
    end
  end

endmodule // dmic_link

// *** verification/adc_dmic_dc_measure_assertions.sv ***
`timescale 1ns/1ps
module adc_dmic_dc_measure_assertions
  import dc_measure_pkg::*;
#(
  parameter int HALF_CYCLES = MOD_CLK_HALF_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input reg_req_t reg_req_in,
  input wire logic dmic_enable_in,
  input wire logic analog_valid_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic general_pin_one_out,
  input wire logic general_pin_one_oe_n_out,
  input wire logic decim_valid_out
);
  // a write that lands on the pin configuration register
  wire cfg_wr = reg_req_in.wr && reg_req_in.addr == PIN_CONFIG_OFFSET;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // microphone bit with the mode settled long enough to flush analog bits
  sequence mic_pulse_s;
    decim_valid_out && dmic_enable_in && $past(dmic_enable_in, 4);
  endsequence
  sequence clk_select_s;
    cfg_wr &&
      reg_req_in.wdata[PIN_FUNC_MSB:PIN_FUNC_LSB] == PIN_FUNC_MOD_CLOCK;
  endsequence
  read_answer_a:
    assert property (reg_req_in.rd |=> reg_rvalid_out)
    else $error("read unanswered");
  no_stray_a:
    assert property (!reg_req_in.rd |=> !reg_rvalid_out)
    else $error("answer without read");
  rdata_hold_a:
    assert property (!reg_rvalid_out |-> $stable(reg_rdata_out))
    else $error("read data moved");
  pin_enable_a:
    assert property (clk_select_s |-> ##[1:2] !general_pin_one_oe_n_out)
    else $error("pin not driven");
  pin_cause_a:
    assert property ($changed(general_pin_one_oe_n_out) |->
      $past(cfg_wr) || $past(cfg_wr, 2)) else $error("pin enable moved");
  pin_period_a:
    assert property ($changed(general_pin_one_out) |->
      ##HALF_CYCLES $changed(general_pin_one_out))
    else $error("bad half period");
  mic_gap_a:
    assert property (mic_pulse_s |=> (!decim_valid_out || !dmic_enable_in)[*8])
    else $error("mic bits too close");
  analog_pass_a:
    assert property ((!dmic_enable_in)[*3] ##0 analog_valid_in |->
      ##[1:2] (decim_valid_out || dmic_enable_in))
    else $error("analog bit lost");
endmodule // adc_dmic_dc_measure_assertions

bind adc_dmic_dc_measure adc_dmic_dc_measure_assertions #(
  .HALF_CYCLES(HALF_CYCLES)
) chk (.clk_in(clk_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
  .dmic_enable_in(dmic_enable_in), .analog_valid_in(analog_valid_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .general_pin_one_out(general_pin_one_out),
  .general_pin_one_oe_n_out(general_pin_one_oe_n_out),
  .decim_valid_out(decim_valid_out));

// *** verification/adc_dmic_dc_measure_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module adc_dmic_dc_measure_tb;
  import dc_measure_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  reg_req_t req = '0;
  logic dmic = 1'b1;
  logic abit = 1'b0;
  logic avalid = 1'b0;
  logic din, pin, oe_n, rvalid, pdown, dbit, dvalid;
  logic [7:0] rdata;
  logic [3:0] pattern = 4'hf;
  int n_mismatch = 0;
  int tests_run = 0;
  // short half period keeps the run brief
  adc_dmic_dc_measure #(.HALF_CYCLES(5)) uut (.clk_in(clk_in),
    .rst_in(rst_in), .reg_req_in(req), .din_in(din), .dmic_enable_in(dmic),
    .analog_bit_in(abit), .analog_valid_in(avalid), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .general_pin_one_out(pin),
    .general_pin_one_oe_n_out(oe_n), .analog_powerdown_out(pdown),
    .decim_bit_out(dbit), .decim_valid_out(dvalid));
  // oversampling ratio lives outside this block; one fixed mic rate
  dmic_model mic (.mod_clk_in(pin), .oe_n_in(oe_n), .pattern_in(pattern),
    .data_out(din));
  initial forever #2.5 clk_in = ~clk_in;
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // inputs move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    step(1);
    req.wr = 1'b0;
    // one idle edge so the next access never re-raises the strobe at once
    step(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    req.rd = 1'b1;
    req.addr = a;
    step(1);
    req.rd = 1'b0;
    `CHK({rvalid, rdata}, {1'b1, e})
    step(1);
  endtask
  task automatic wait_valid();
    int i;
    step(1);
    for (i = 0; i < 40 && dvalid !== 1'b1; i++)
      step(1);
    if (dvalid !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  // capture, read the three bytes high first, then release the capture
  task automatic latch(input logic [7:0] aux, input logic [23:0] e);
    wr(DC_MEASURE_AUX_CONTROL_OFFSET, aux | 8'h40);
    step(2);
    rd(DC_RESULT_READBACK_FIRST_OFFSET, e[23:16]);
    rd(DC_RESULT_READBACK_MID_OFFSET, e[15:8]);
    rd(DC_RESULT_READBACK_LAST_OFFSET, e[7:0]);
    wr(DC_MEASURE_AUX_CONTROL_OFFSET, aux);
  endtask
  // reset values, a write to a result byte, an unmapped place
  task automatic t_regs();
    wr(DC_RESULT_READBACK_FIRST_OFFSET, 8'h5a);
    rd(DC_RESULT_READBACK_FIRST_OFFSET, DC_RESULT_RESET[23:16]);
    rd(DC_MEASURE_CONTROL_OFFSET, DC_MEASURE_CONTROL_RESET);
    rd(DC_MEASURE_AUX_CONTROL_OFFSET, DC_MEASURE_AUX_CONTROL_RESET);
    rd(8'h70, 8'h00);
    `CHK(oe_n, 1'b1)
  endtask
  // only function 1010 puts the modulator clock on the pin
  task automatic t_pin();
    wr(PIN_CONFIG_OFFSET, 8'h28);
    step(1);
    `CHK(oe_n, 1'b0)
    wr(PIN_CONFIG_OFFSET, 8'h24);
    step(1);
    `CHK(oe_n, 1'b1)
    wr(PIN_CONFIG_OFFSET, 8'h28);
    rd(PIN_CONFIG_OFFSET, 8'h28);
  endtask
  // mic bits reach the decimation path, then an analog bit once analog is selected
  task automatic t_path();
    repeat (5) wait_valid();
    `CHK({pdown, dbit}, 2'b11)
    pattern = 4'h0;
    repeat (5) wait_valid();
    `CHK(dbit, 1'b0)
    dmic = 1'b0;
    step(12);
    abit = 1'b1;
    avalid = 1'b1;
    step(1);
    avalid = 1'b0;
    // the registered copy stands only in this one cycle
    `CHK({pdown, dbit, dvalid}, 3'b011)
    dmic = 1'b1;
  endtask
  // block averaging over four bits, then the capture is held
  task automatic t_avg();
    wr(DC_MEASURE_CONTROL_OFFSET, 8'h82);
    pattern = 4'hf;
    step(200);
    latch(8'h00, 24'h400000);
    pattern = 4'h5;
    step(200);
    latch(8'h00, 24'h000000);
    pattern = 4'h0;
    step(200);
    wr(DC_MEASURE_AUX_CONTROL_OFFSET, 8'h40);
    step(2);
    rd(DC_RESULT_READBACK_FIRST_OFFSET, 8'hc0);
    pattern = 4'hf;
    step(200);
    rd(DC_RESULT_READBACK_FIRST_OFFSET, 8'hc0);
    wr(DC_MEASURE_AUX_CONTROL_OFFSET, 8'h00);
    latch(8'h00, 24'h400000);
  endtask
  // reset period equal to the block: no block ever completes
  task automatic t_periodic();
    wr(DC_MEASURE_CONTROL_OFFSET, 8'h02);
    wr(DC_MEASURE_AUX_CONTROL_OFFSET, 8'h22);
    pattern = 4'h0;
    wr(DC_MEASURE_CONTROL_OFFSET, 8'h82);
    step(300);
    latch(8'h22, 24'h400000);
    // period of two blocks: the first block of each period completes
    wr(DC_MEASURE_AUX_CONTROL_OFFSET, 8'h23);
    step(200);
    latch(8'h23, 24'hc00000);
    pattern = 4'hf;
    wr(DC_MEASURE_AUX_CONTROL_OFFSET, 8'h02);
    step(200);
    latch(8'h02, 24'h400000);
  endtask
  // first-order filter settles one step below +1.0
  task automatic t_iir();
    wr(DC_MEASURE_CONTROL_OFFSET, 8'h21);
    pattern = 4'hf;
    wr(DC_MEASURE_CONTROL_OFFSET, 8'ha1);
    step(900);
    latch(8'h02, 24'h3fffff);
  endtask
  initial begin
    step(4);
    rst_in = 1'b0;
    t_regs();
    t_pin();
    t_path();
    // dc measurement runs on the microphone bits that still feed the decimation path
    t_avg();
    t_periodic();
    t_iir();
    stop_test();
  end
endmodule // adc_dmic_dc_measure_tb

// *** verification/dmic_model.sv ***
`timescale 1ns/1ps
module dmic_model (
  input wire logic mod_clk_in,
  input wire logic oe_n_in,
  input wire logic [3:0] pattern_in,
  output logic data_out
);
  logic [1:0] idx = 2'h0;
  logic last = 1'b0;
  // next bit after the falling edge, steady through the rising edge
  always @(negedge mod_clk_in) begin
    if (!oe_n_in) begin
      last <= pattern_in[idx];
      idx <= idx + 2'h1;
    end
  end
  // with no clock the line floats, so never show a believable last bit
  assign data_out = oe_n_in ? ~last : last;
endmodule // dmic_model
